// ===== common/sdcd_regs.svh
// Constants for the SDRAM command decoder: widths, field positions, reset values and timing counts
`ifndef SDCD_REGS_SVH
`define SDCD_REGS_SVH

`define SDCD_ADDR_W        13
`define SDCD_COL_W         10
`define SDCD_DQ_W          16
`define SDCD_DQM_W         2
`define SDCD_MODE_W        12
`define SDCD_AP_BIT        10
`define SDCD_MODE_RST      12'h000
`define SDCD_BL_LSB        0
`define SDCD_BT_BIT        3
`define SDCD_FIFO_DEPTH    16
`define SDCD_READ_DQM_LAT  2
`define SDCD_CLK_MHZ       50
`define SDCD_MRD_CK        2
`define SDCD_REF_CNT_RST   13'h0000

`endif

// ===== common/sdcd_pkg.sv
// Types shared by the SDRAM command decoder modules
package sdcd_pkg;

  typedef enum logic [3:0] {
    SDCD_CMD_INHIBIT,
    SDCD_CMD_NOP,
    SDCD_CMD_ACTIVATE,
    SDCD_CMD_READ,
    SDCD_CMD_WRITE,
    SDCD_CMD_BURST_STOP,
    SDCD_CMD_DEEP_SLEEP,
    SDCD_CMD_PRECHARGE,
    SDCD_CMD_AUTO_REFRESH,
    SDCD_CMD_SELF_REFRESH,
    SDCD_CMD_MODE_LOAD
  } sdcd_cmd_t;

  typedef enum logic [1:0] {
    SDCD_PWR_ACTIVE,
    SDCD_PWR_SELF_REFRESH,
    SDCD_PWR_DEEP_SLEEP
  } sdcd_pwr_t;

  typedef enum logic [1:0] {
    SDCD_BURST_IDLE,
    SDCD_BURST_READ,
    SDCD_BURST_WRITE
  } sdcd_burst_t;

endpackage

// ===== rtl/sdcd_fifo.sv
// Parameterised valid/ready FIFO used in the read data path
`timescale 1ns/1ps
module sdcd_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic             push;
  logic             pop;

  assign in_ready  = (count_reg != (AW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data  = mem[rd_ptr_reg];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  fifo_bound_a: assert property (@(posedge clk) disable iff (rst)
    count_reg <= (AW+1)'(DEPTH))
    else $error("FIFO count exceeds depth");
endmodule

// ===== rtl/sdcd_bank.sv
// One bank's open-row state with self-timed auto precharge
`timescale 1ns/1ps
`include "sdcd_regs.svh"
module sdcd_bank (
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst,
  // Commands decoded for this bank
  input  wire logic                      activate,
  input  wire logic [`SDCD_ADDR_W-1:0]   row,
  input  wire logic                      precharge,
  input  wire logic                      arm_auto_pre,
  input  wire logic                      burst_done,
  // State
  output logic                           row_open,
  output logic      [`SDCD_ADDR_W-1:0]   open_row,
  output logic                           auto_pre_pending
);
  always_ff @(posedge clk) begin
    if (rst) begin
      row_open <= 1'b0;
      open_row <= '0;
    end else if (precharge || (auto_pre_pending && burst_done)) begin
      row_open <= 1'b0;
    end else if (activate) begin
      row_open <= 1'b1;
      open_row <= row;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      auto_pre_pending <= 1'b0;
    end else if (arm_auto_pre) begin
      auto_pre_pending <= 1'b1;
    end else if (burst_done || precharge) begin
      auto_pre_pending <= 1'b0;
    end
  end
endmodule

// ===== rtl/sdcd_top.sv
// SDRAM command decoder and bank-control front end
`timescale 1ns/1ps
`include "sdcd_regs.svh"
// ============================================================
// Notes on behaviour
// - All inputs sampled on rising clock only
// - Four banks; activate picks bank and row
// - Chip select high: no new command
// - All strobes high is no-operation
// - Activate opens addressed row in bank
// - Row stays open until bank precharged
// - Read and write pick bank and column
// - Address bit ten: auto precharge, this access
// - Auto precharge closes row after burst
// - Burst stop, or deep sleep if clock-enable low
// - Precharge one bank, or all with bit ten
// - Auto refresh, or self refresh if clock-enable low
// - Refresh rows come from internal counter
// - Mode load takes address bits eleven to zero
// - Write mask applies in same cycle
// - Read mask floats outputs two cycles later (here three)
// - New column accepted every clock
// - Banks run independently
// - Burst walks columns internally per mode
// - Burst stop truncates latest read or write
// - Deep sleep entered idle, left on clock-enable
module sdcd_top
  import sdcd_pkg::*;
(
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst,
  // Command pins
  input  wire logic                     clk_en,
  input  wire logic                     chip_sel_n,
  input  wire logic                     row_strobe_n,
  input  wire logic                     col_strobe_n,
  input  wire logic                     write_strobe_n,
  input  wire logic                     bank_select_lo,
  input  wire logic                     bank_select_hi,
  input  wire logic [`SDCD_ADDR_W-1:0]  addr,
  input  wire logic [`SDCD_DQM_W-1:0]   byte_mask,
  // Data pins, split three ways
  input  wire logic [`SDCD_DQ_W-1:0]    dq_in,
  output logic      [`SDCD_DQ_W-1:0]    dq_out,
  output logic      [`SDCD_DQM_W-1:0]   dq_oe_n,
  // Array side: write port
  output logic                          arr_wr_en,
  output logic      [1:0]               arr_bank,
  output logic      [`SDCD_ADDR_W-1:0]  arr_row,
  output logic      [`SDCD_COL_W-1:0]   arr_col,
  output logic      [`SDCD_DQ_W-1:0]    arr_wr_data,
  output logic      [`SDCD_DQM_W-1:0]   arr_wr_byte_en,
  // Array side: read request and returned data
  output logic                          arr_rd_en,
  input  wire logic                     arr_rd_valid,
  output logic                          arr_rd_ready,
  input  wire logic [`SDCD_DQ_W-1:0]    arr_rd_data,
  // Refresh and status
  output logic                          refresh_pulse,
  output logic      [`SDCD_ADDR_W-1:0]  refresh_row,
  output logic      [`SDCD_MODE_W-1:0]  mode_reg,
  output logic      [3:0]               bank_open,
  output logic      [1:0]               power_state
);
  // ============================================================
  // Command decode
  function automatic sdcd_cmd_t decode(input logic cs_n, input logic ras_n, input logic cas_n,
                                       input logic we_n, input logic cke);
    sdcd_cmd_t c;
    c = SDCD_CMD_NOP;
    if (cs_n) begin
      c = SDCD_CMD_INHIBIT;
    end else begin
      case ({ras_n, cas_n, we_n})
        3'h7: c = SDCD_CMD_NOP;
        3'h3: c = SDCD_CMD_ACTIVATE;
        3'h5: c = SDCD_CMD_READ;
        3'h4: c = SDCD_CMD_WRITE;
        3'h6: c = cke ? SDCD_CMD_BURST_STOP : SDCD_CMD_DEEP_SLEEP;
        3'h2: c = SDCD_CMD_PRECHARGE;
        3'h1: c = cke ? SDCD_CMD_AUTO_REFRESH : SDCD_CMD_SELF_REFRESH;
        3'h0: c = SDCD_CMD_MODE_LOAD;
        default: c = SDCD_CMD_NOP;
      endcase
    end
    return c;
  endfunction

  // Burst length from the mode field; full page maps to all columns
  function automatic logic [`SDCD_COL_W:0] burst_len(input logic [2:0] code);
    logic [`SDCD_COL_W:0] n;
    n = '0;
    case (code)
      3'h0:    n = 11'h001;
      3'h1:    n = 11'h002;
      3'h2:    n = 11'h004;
      3'h3:    n = 11'h008;
      3'h7:    n = 11'h400;
      default: n = 11'h001;
    endcase
    return n;
  endfunction

  // ============================================================
  // Input register stage
  logic                    cke_reg;
  logic                    cs_n_reg;
  logic                    ras_n_reg;
  logic                    cas_n_reg;
  logic                    we_n_reg;
  logic [1:0]              ba_reg;
  logic [`SDCD_ADDR_W-1:0] addr_reg;
  logic [`SDCD_DQM_W-1:0]  dqm_reg;
  logic [`SDCD_DQ_W-1:0]   dq_reg;
  logic [`SDCD_DQ_W-1:0]   wr_data_d_reg;
  logic [`SDCD_DQM_W-1:0]  wr_mask_d_reg;
  sdcd_cmd_t               cmd;

  always_ff @(posedge clk) begin
    if (rst) begin
      cke_reg   <= 1'b1;
      cs_n_reg  <= 1'b1;
      ras_n_reg <= 1'b1;
      cas_n_reg <= 1'b1;
      we_n_reg  <= 1'b1;
      ba_reg    <= '0;
      addr_reg  <= '0;
      dqm_reg   <= '1;
      dq_reg    <= '0;
      wr_data_d_reg <= '0;
      wr_mask_d_reg <= '1;
    end else begin
      cke_reg   <= clk_en;
      cs_n_reg  <= chip_sel_n;
      ras_n_reg <= row_strobe_n;
      cas_n_reg <= col_strobe_n;
      we_n_reg  <= write_strobe_n;
      ba_reg    <= {bank_select_hi, bank_select_lo};
      addr_reg  <= addr;
      dqm_reg   <= byte_mask;
      dq_reg    <= dq_in;
      wr_data_d_reg <= dq_reg;
      wr_mask_d_reg <= dqm_reg;
    end
  end

  // Commands are ignored while asleep except for the wake condition
  logic awake;
  assign awake = (power_state == 2'(SDCD_PWR_ACTIVE));
  assign cmd = awake ? decode(cs_n_reg, ras_n_reg, cas_n_reg, we_n_reg, cke_reg)
                     : SDCD_CMD_INHIBIT;

  // ============================================================
  // Mode register and power state
  always_ff @(posedge clk) begin
    if (rst) begin
      mode_reg <= `SDCD_MODE_RST;
    end else if (cmd == SDCD_CMD_MODE_LOAD) begin
      mode_reg <= addr_reg[`SDCD_MODE_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      power_state <= 2'(SDCD_PWR_ACTIVE);
    end else if (!awake && cke_reg) begin
      power_state <= 2'(SDCD_PWR_ACTIVE);
    end else if (cmd == SDCD_CMD_SELF_REFRESH) begin
      power_state <= 2'(SDCD_PWR_SELF_REFRESH);
    end else if (cmd == SDCD_CMD_DEEP_SLEEP && bank_open == 4'h0) begin
      power_state <= 2'(SDCD_PWR_DEEP_SLEEP);
    end
  end

  // ============================================================
  // Refresh counter; address pins play no part
  always_ff @(posedge clk) begin
    if (rst) begin
      refresh_row   <= `SDCD_REF_CNT_RST;
      refresh_pulse <= 1'b0;
    end else begin
      refresh_pulse <= (cmd == SDCD_CMD_AUTO_REFRESH);
      if (cmd == SDCD_CMD_AUTO_REFRESH) begin
        refresh_row <= refresh_row + 1'b1;
      end
    end
  end

  // ============================================================
  // Burst engine: one active burst, restarted by every new column
  sdcd_burst_t             burst_reg;
  logic [1:0]              burst_bank_reg;
  logic [`SDCD_COL_W-1:0]  start_col_reg;
  logic [`SDCD_COL_W:0]    beat_reg;
  logic [`SDCD_COL_W:0]    len_reg;
  logic                    burst_last;
  logic                    rw_cmd;
  logic                    fifo_in_ready;
  logic [`SDCD_COL_W-1:0]  cur_col;

  assign rw_cmd     = (cmd == SDCD_CMD_READ) || (cmd == SDCD_CMD_WRITE);
  assign burst_last = (burst_reg != SDCD_BURST_IDLE) && (beat_reg + 1'b1 == len_reg);

  // Interleaved order xors the beat count into the start column
  always_comb begin
    if (mode_reg[`SDCD_BT_BIT]) begin
      cur_col = start_col_reg ^ beat_reg[`SDCD_COL_W-1:0];
    end else begin
      cur_col = start_col_reg + beat_reg[`SDCD_COL_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      burst_reg      <= SDCD_BURST_IDLE;
      burst_bank_reg <= '0;
      start_col_reg  <= '0;
      beat_reg       <= '0;
      len_reg        <= 11'h001;
    end else if (rw_cmd) begin
      burst_reg      <= (cmd == SDCD_CMD_READ) ? SDCD_BURST_READ : SDCD_BURST_WRITE;
      burst_bank_reg <= ba_reg;
      start_col_reg  <= addr_reg[`SDCD_COL_W-1:0];
      beat_reg       <= '0;
      len_reg        <= burst_len(mode_reg[`SDCD_BL_LSB +: 3]);
    end else if (cmd == SDCD_CMD_BURST_STOP) begin
      burst_reg <= SDCD_BURST_IDLE;
    end else if (burst_reg != SDCD_BURST_IDLE && (fifo_in_ready || burst_reg == SDCD_BURST_WRITE)) begin
      if (burst_last) begin
        burst_reg <= SDCD_BURST_IDLE;
      end else begin
        beat_reg <= beat_reg + 1'b1;
      end
    end
  end

  // The beat due this cycle still goes out when a new command or a stop lands
  logic burst_step;
  assign burst_step = (burst_reg != SDCD_BURST_IDLE);

  // ============================================================
  // Banks
  logic [`SDCD_ADDR_W-1:0] open_row [4];
  logic [3:0]              ap_pending;

  for (genvar b = 0; b < 4; b++) begin : g_bank
    logic act_b;
    logic pre_b;
    logic arm_b;
    logic done_b;
    assign act_b  = (cmd == SDCD_CMD_ACTIVATE) && (ba_reg == 2'(b));
    assign pre_b  = (cmd == SDCD_CMD_PRECHARGE)
                    && (addr_reg[`SDCD_AP_BIT] || ba_reg == 2'(b));
    assign arm_b  = rw_cmd && addr_reg[`SDCD_AP_BIT] && (ba_reg == 2'(b));
    assign done_b = (burst_bank_reg == 2'(b)) && burst_last && burst_step
                    && (fifo_in_ready || burst_reg == SDCD_BURST_WRITE);
    sdcd_bank u_bank (
      .clk              (clk),
      .rst              (rst),
      .activate         (act_b),
      .row              (addr_reg),
      .precharge        (pre_b),
      .arm_auto_pre     (arm_b),
      .burst_done       (done_b),
      .row_open         (bank_open[b]),
      .open_row         (open_row[b]),
      .auto_pre_pending (ap_pending[b])
    );
  end

  // ============================================================
  // Array access
  logic beat_go;
  assign beat_go = burst_step && (fifo_in_ready || burst_reg == SDCD_BURST_WRITE);

  always_ff @(posedge clk) begin
    if (rst) begin
      arr_wr_en      <= 1'b0;
      arr_rd_en      <= 1'b0;
      arr_bank       <= '0;
      arr_row        <= '0;
      arr_col        <= '0;
      arr_wr_data    <= '0;
      arr_wr_byte_en <= '0;
    end else begin
      arr_wr_en      <= beat_go && burst_reg == SDCD_BURST_WRITE;
      arr_rd_en      <= beat_go && burst_reg == SDCD_BURST_READ;
      arr_bank       <= burst_bank_reg;
      arr_row        <= open_row[burst_bank_reg];
      arr_col        <= cur_col;
      arr_wr_data    <= wr_data_d_reg;
      arr_wr_byte_en <= ~wr_mask_d_reg;
    end
  end

  // ============================================================
  // Read data path: FIFO absorbs array latency and stalls the burst
  logic                   fifo_out_valid;
  logic [`SDCD_DQ_W-1:0]  fifo_out_data;
  logic [`SDCD_DQM_W-1:0] dqm_d1_reg;

  sdcd_fifo #(
    .WIDTH (`SDCD_DQ_W),
    .DEPTH (`SDCD_FIFO_DEPTH)
  ) u_rd_fifo (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (arr_rd_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (arr_rd_data),
    .out_valid (fifo_out_valid),
    .out_ready (1'b1),
    .out_data  (fifo_out_data)
  );
  assign arr_rd_ready = fifo_in_ready;

  // Mask pipeline gives the three-clock float delay on reads
  always_ff @(posedge clk) begin
    if (rst) begin
      dqm_d1_reg <= '1;
      dq_out     <= '0;
      dq_oe_n    <= '1;
    end else begin
      dqm_d1_reg <= dqm_reg;
      dq_out     <= fifo_out_data;
      dq_oe_n    <= fifo_out_valid ? dqm_d1_reg : '1;
    end
  end

  // ============================================================
  // Checks
  inhibit_no_act_a: assert property (@(posedge clk) disable iff (rst)
    cs_n_reg |-> cmd == SDCD_CMD_INHIBIT)
    else $error("Command taken while deselected");
  activate_opens_a: assert property (@(posedge clk) disable iff (rst)
    cmd == SDCD_CMD_ACTIVATE && !(cmd == SDCD_CMD_PRECHARGE) |=> bank_open[$past(ba_reg)])
    else $error("Activate did not open the bank");
  pre_all_a: assert property (@(posedge clk) disable iff (rst)
    cmd == SDCD_CMD_PRECHARGE && addr_reg[`SDCD_AP_BIT] |=> bank_open == 4'h0)
    else $error("Precharge all left a bank open");
  mode_load_a: assert property (@(posedge clk) disable iff (rst)
    cmd == SDCD_CMD_MODE_LOAD |=> mode_reg == $past(addr_reg[`SDCD_MODE_W-1:0]))
    else $error("Mode register not loaded");
  refresh_count_a: assert property (@(posedge clk) disable iff (rst)
    cmd == SDCD_CMD_AUTO_REFRESH |=> refresh_row == $past(refresh_row) + 1'b1)
    else $error("Refresh counter did not advance");
  burst_stop_a: assert property (@(posedge clk) disable iff (rst)
    cmd == SDCD_CMD_BURST_STOP |=> burst_reg == SDCD_BURST_IDLE)
    else $error("Burst stop did not end burst");
  write_mask_a: assert property (@(posedge clk) disable iff (rst)
    arr_wr_en |-> arr_wr_byte_en == ~$past(dqm_reg, 2))
    else $error("Write mask not applied in its cycle");
  read_float_a: assert property (@(posedge clk) disable iff (rst)
    dqm_reg[0] ##1 1'b1 |=> dq_oe_n[0])
    else $error("Read data driven against mask");
  deep_exit_a: assert property (@(posedge clk) disable iff (rst)
    power_state == 2'(SDCD_PWR_DEEP_SLEEP) && cke_reg |=> power_state == 2'(SDCD_PWR_ACTIVE))
    else $error("Deep sleep not left on clock enable");

  cov_read_c:  cover property (@(posedge clk) cmd == SDCD_CMD_READ ##[1:8] arr_rd_en);
  cov_ap_c:    cover property (@(posedge clk) |ap_pending ##[1:20] bank_open == 4'h0);
  cov_self_c:  cover property (@(posedge clk) cmd == SDCD_CMD_SELF_REFRESH);
  cov_full_c:  cover property (@(posedge clk) !fifo_in_ready);
endmodule

// ===== dv/sdcd_array_model.sv
// Memory array stand-in that answers read beat requests from the decoder
`timescale 1ns/1ps
`include "sdcd_regs.svh"
module sdcd_array_model (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst,
  // Answer pace: high adds three idle cycles per beat
  input  wire logic                     slow,
  // Read requests from the decoder
  input  wire logic                     arr_rd_en,
  input  wire logic [1:0]               arr_bank,
  input  wire logic [`SDCD_COL_W-1:0]   arr_col,
  // Returned data
  input  wire logic                     arr_rd_ready,
  output logic                          arr_rd_valid,
  output logic      [`SDCD_DQ_W-1:0]    arr_rd_data
);
  logic [`SDCD_DQ_W-1:0] pend[$];
  logic [1:0]            gap;

  // ============================================================
  // Beat queue
  // Data encodes bank and column so a wrong address shows in the word
  always @(posedge clk) begin
    if (rst) begin
      pend.delete();
      arr_rd_valid <= 1'b0;
      arr_rd_data  <= 16'h0000;
      gap          <= 2'h0;
    end else begin
      if (arr_rd_en === 1'b1)
        pend.push_back({4'ha, arr_bank, arr_col});
      if (arr_rd_valid && arr_rd_ready) begin
        // Released data is inverted so a stale word never looks valid
        arr_rd_valid <= 1'b0;
        arr_rd_data  <= ~arr_rd_data;
        gap          <= slow ? 2'h3 : 2'h0;
      end else if (!arr_rd_valid && gap != 2'h0) begin
        gap <= gap - 2'h1;
      end else if (!arr_rd_valid && pend.size() > 0) begin
        arr_rd_valid <= 1'b1;
        arr_rd_data  <= pend.pop_front();
      end
    end
  end
endmodule

// ===== dv/sdram_command_decoder_bench.sv
// Self-checking bench for the SDRAM command decoder
`timescale 1ns/1ps
`include "sdcd_regs.svh"
module sdram_command_decoder_bench;
  // Command codes {cs, ras, cas, we}
  localparam logic [3:0] NOP = 4'b0111, ACT = 4'b0011, RD = 4'b0101, WR = 4'b0100;
  localparam logic [3:0] BST = 4'b0110, PRE = 4'b0010, REF = 4'b0001, MRS = 4'b0000;
  logic clk = 1'b0, rst = 1'b1, clk_en = 1'b1, slow = 1'b0;
  logic cs_n = 1'b1, ras_n = 1'b1, cas_n = 1'b1, we_n = 1'b1, ba_lo = 1'b0, ba_hi = 1'b0;
  logic [`SDCD_ADDR_W-1:0] addr = 13'h0000;
  logic [`SDCD_DQM_W-1:0]  mask = 2'h0;
  logic [`SDCD_DQ_W-1:0]   dq_in = 16'h0000;
  logic [`SDCD_DQ_W-1:0]   dq_out, arr_wr_data, arr_rd_data;
  logic [`SDCD_DQM_W-1:0]  dq_oe_n, arr_wr_byte_en;
  logic [`SDCD_ADDR_W-1:0] arr_row, refresh_row;
  logic [`SDCD_COL_W-1:0]  arr_col;
  logic [`SDCD_MODE_W-1:0] mode_reg;
  logic [3:0]              bank_open;
  logic [1:0]              arr_bank, power_state;
  logic arr_wr_en, arr_rd_en, arr_rd_valid, arr_rd_ready, refresh_pulse;
  int bad_count = 0, check_count = 0, rd_n, ref_n, drv_n;
  logic [31:0] wr_q[$], rd_q[$];

  always #10 clk = ~clk;

  sdcd_top uut (.clk(clk), .rst(rst), .clk_en(clk_en), .chip_sel_n(cs_n), .row_strobe_n(ras_n),
    .col_strobe_n(cas_n), .write_strobe_n(we_n), .bank_select_lo(ba_lo), .bank_select_hi(ba_hi),
    .addr(addr), .byte_mask(mask), .dq_in(dq_in), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
    .arr_wr_en(arr_wr_en), .arr_bank(arr_bank), .arr_row(arr_row), .arr_col(arr_col),
    .arr_wr_data(arr_wr_data), .arr_wr_byte_en(arr_wr_byte_en), .arr_rd_en(arr_rd_en),
    .arr_rd_valid(arr_rd_valid), .arr_rd_ready(arr_rd_ready), .arr_rd_data(arr_rd_data),
    .refresh_pulse(refresh_pulse), .refresh_row(refresh_row), .mode_reg(mode_reg),
    .bank_open(bank_open), .power_state(power_state));

  sdcd_array_model array_model (.clk(clk), .rst(rst), .slow(slow), .arr_rd_en(arr_rd_en),
    .arr_bank(arr_bank), .arr_col(arr_col), .arr_rd_ready(arr_rd_ready),
    .arr_rd_valid(arr_rd_valid), .arr_rd_data(arr_rd_data));

  // ============================================================
  // Monitors
  always @(posedge clk) begin
    if (arr_wr_en === 1'b1)
      wr_q.push_back({arr_wr_byte_en, arr_bank, arr_col[3:0], arr_row[7:0], arr_wr_data});
    if (arr_rd_en === 1'b1)
      rd_n++;
    if (refresh_pulse === 1'b1)
      ref_n++;
    if (dq_oe_n !== 2'b11)
      drv_n++;
    if (dq_oe_n === 2'b00)
      rd_q.push_back({16'h0000, dq_out});
  end

  // ============================================================
  // Shared tasks
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One command for one cycle; inputs change only at rising edges
  task automatic cmd(input logic cke, input logic [3:0] c, input logic [1:0] ba,
                     input logic [12:0] a, input logic [1:0] m);
    @(posedge clk);
    clk_en <= cke;
    {cs_n, ras_n, cas_n, we_n} <= c;
    {ba_hi, ba_lo} <= ba;
    addr <= a;
    mask <= m;
  endtask

  // Idle cycles carry a no-operation code
  task automatic idle(input int n, input logic cke);
    repeat (n) cmd(cke, NOP, 2'h0, 13'h0000, 2'h0);
  endtask

  // Banks closed before a mode load, then the recovery gap
  task automatic mode_load(input logic [11:0] op);
    cmd(1'b1, PRE, 2'h0, 13'h0400, 2'h0);
    idle(2, 1'b1);
    cmd(1'b1, MRS, 2'h0, {1'b1, op}, 2'h0);
    idle(3, 1'b1);
  endtask

  task automatic clear_mon;
    wr_q.delete();
    rd_q.delete();
    rd_n = 0;
    ref_n = 0;
    drv_n = 0;
  endtask

  // ============================================================
  // Scenarios
  task automatic t_reset;
    chk("dq_oe_n", 32'h3, dq_oe_n);
    chk("mode_reg", 32'h0, mode_reg);
    chk("bank_open", 32'h0, bank_open);
    chk("power_state", 32'h0, power_state);
    $display("test reset done");
  endtask

  task automatic t_mode;
    mode_load(12'h023);
    chk("mode_reg", 32'h023, mode_reg);
    cmd(1'b1, 4'b1000, 2'h0, 13'h0fff, 2'h0);
    idle(4, 1'b1);
    chk("mode_reg inhibit", 32'h023, mode_reg);
    $display("test mode done");
  endtask

  task automatic t_banks;
    for (int b = 0; b < 4; b++)
      cmd(1'b1, ACT, b[1:0], 13'h0100 + 13'(b), 2'h0);
    idle(4, 1'b1);
    chk("bank_open all", 32'hf, bank_open);
    cmd(1'b1, PRE, 2'h1, 13'h0000, 2'h0);
    idle(4, 1'b1);
    chk("bank_open one", 32'hd, bank_open);
    cmd(1'b1, PRE, 2'h1, 13'h0400, 2'h0);
    idle(4, 1'b1);
    chk("bank_open none", 32'h0, bank_open);
    $display("test banks done");
  endtask

  task automatic t_write;
    mode_load(12'h001);
    clear_mon();
    cmd(1'b1, ACT, 2'h2, 13'h0033, 2'h0);
    idle(2, 1'b1);
    dq_in <= 16'h5a3c;
    cmd(1'b1, WR, 2'h2, 13'h0404, 2'h1);
    idle(12, 1'b1);
    chk("write beats", 32'h2, wr_q.size());
    if (wr_q.size() == 2) begin
      chk("write beat 0", 32'ha4335a3c, wr_q[0]);
      chk("write beat 1", 32'he5335a3c, wr_q[1]);
    end
    chk("auto precharge", 32'h0, bank_open);
    $display("test write done");
  endtask

  task automatic t_read;
    mode_load(12'h000);
    clear_mon();
    slow <= 1'b1;
    cmd(1'b1, ACT, 2'h0, 13'h0044, 2'h0);
    idle(2, 1'b1);
    cmd(1'b1, RD, 2'h0, 13'h0008, 2'h0);
    cmd(1'b1, RD, 2'h0, 13'h0009, 2'h0);
    // Mask gates what leaves three cycles later: only the slow second word floats
    idle(4, 1'b1);
    repeat (4) cmd(1'b1, NOP, 2'h0, 13'h0000, 2'h3);
    idle(12, 1'b1);
    chk("read beats", 32'h2, rd_n);
    chk("read words", 32'h1, rd_q.size());
    if (rd_q.size() > 0)
      chk("read data", 32'ha008, rd_q[0]);
    chk("row kept", 32'h1, bank_open);
    slow <= 1'b0;
    $display("test read done");
  endtask

  task automatic t_stop;
    mode_load(12'h003);
    clear_mon();
    cmd(1'b1, ACT, 2'h0, 13'h0044, 2'h0);
    idle(2, 1'b1);
    cmd(1'b1, RD, 2'h0, 13'h0000, 2'h3);
    cmd(1'b1, BST, 2'h0, 13'h0000, 2'h3);
    repeat (6) cmd(1'b1, NOP, 2'h0, 13'h0000, 2'h3);
    idle(10, 1'b1);
    chk("burst cut", 32'h1, rd_n);
    chk("masked output", 32'h0, drv_n);
    $display("test stop done");
  endtask

  task automatic t_power;
    cmd(1'b1, PRE, 2'h0, 13'h0400, 2'h0);
    idle(2, 1'b1);
    clear_mon();
    cmd(1'b1, REF, 2'h3, 13'h1fff, 2'h3);
    idle(6, 1'b1);
    chk("refresh pulses", 32'h1, ref_n);
    chk("bank_open refresh", 32'h0, bank_open);
    chk("refresh_row", 32'h1, refresh_row);
    cmd(1'b0, REF, 2'h0, 13'h0000, 2'h0);
    idle(4, 1'b0);
    chk("self refresh", 32'h1, power_state);
    cmd(1'b0, ACT, 2'h3, 13'h0001, 2'h0);
    idle(4, 1'b0);
    chk("refused act", 32'h0, bank_open);
    idle(6, 1'b1);
    chk("refresh exit", 32'h0, power_state);
    cmd(1'b0, BST, 2'h0, 13'h0000, 2'h0);
    idle(4, 1'b0);
    chk("deep sleep", 32'h2, power_state);
    idle(6, 1'b1);
    chk("deep exit", 32'h0, power_state);
    $display("test power done");
  endtask

  // ============================================================
  // Verdict
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Hang guard: the scripted run is far shorter than this bound
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    $display("BAD watchdog expected finish seen hang");
    final_report();
  end

  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    idle(2, 1'b1);
    t_reset();
    t_mode();
    t_banks();
    t_write();
    t_read();
    t_stop();
    t_power();
    final_report();
  end
endmodule
